// File: spi_port_defines.vh
// Constants for the buffered serial port: register offsets, fields, resets.
`ifndef SPI_PORT_DEFINES_VH
`define SPI_PORT_DEFINES_VH
`define SFR_CFG1        8'hB5
`define SFR_CFG2        8'hB6
`define SFR_STATE       8'hBE
`define SFR_DATA_PORT   8'hBF
`define SEC_TX_BASE     8'h3E
`define SEC_RX_BASE     8'h3F
`define SEC_COUNT_LOW   8'h40
`define SEC_COUNT_HIGH  8'h41
`define CFG1_RESET      8'h15
`define CFG2_RESET      8'h18
`define BIT_RX_FULL_IRQ_ENABLE       7
`define BIT_EN          6
`define BIT_TX_EMPTY_IRQ_ENABLE       5
`define BIT_MSTR        4
`define BIT_CPOL        3
`define BIT_CPHA        2
`define BIT_LSB         1
`define BIT_CS          0
`define BIT_FEEDBACK    6
`define BIT_HS_START    5
`define BIT_TXE         0
`define BIT_OVR         1
`define BIT_RXF         2
`define BASE_SHIFT      4
`define BYTE_BITS       4'h8
`endif

// File: spi_clock_divider.v
// Serial clock tick generator dividing the system clock by 2 to 16.
`timescale 1ns/1ps
module spi_clock_divider (
  // Clock and control
  input  wire       clk,
  input  wire       nrst,
  input  wire       ce,
  input  wire       run,
  input  wire [2:0] clock_divider_sel,
  // Half period tick
  output reg        half_tick
);
  reg [2:0] cnt_q;
  always @(posedge clk) begin
    if (!nrst) begin
      cnt_q     <= 3'h0;
      half_tick <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_q     <= 3'h0;
        half_tick <= 1'b0;
      // divide by two times code plus one
      end else if (cnt_q == clock_divider_sel) begin
        cnt_q     <= 3'h0;
        half_tick <= 1'b1;
      end else begin
        cnt_q     <= cnt_q + 3'h1;
        half_tick <= 1'b0;
      end
    end
  end
endmodule // spi_clock_divider

// File: spi_buffered_serial_port.v
// Buffered serial port with normal and high-speed SRAM streaming modes.
// Function
// - tx_empty_flag bit 0, cleared when a data write is buffered
// - idle first byte to shifter, second buffered
// - data port BFH reads rx, writes tx
// - unread byte kept; overrun drops new byte
// - tx SRAM start is base times 16
// - rx SRAM start is base times 16
// - 12-bit count from two registers
// - irq from flags gated by enables
// - master streams back to back, select low
// - start bit auto cleared when done
// - high-speed bytes move to and from SRAM
// - fast transfer ends at count, sets full
// - serial clock divided by 2 to 16
`timescale 1ns/1ps
`include "spi_port_defines.vh"
module spi_buffered_serial_port (
  // Clock, reset, enable
  input  wire        clk,
  input  wire        nrst,
  input  wire        ce,
  // SFR and secondary register bus
  input  wire [7:0]  reg_addr,
  input  wire        sfr_sel,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // SRAM port
  output reg  [11:0] sram_addr,
  output reg         sram_rd,
  output reg         sram_wr,
  output reg  [7:0]  sram_wdata,
  input  wire [7:0]  sram_rdata,
  // Serial pins
  output reg         sclk_out,
  output reg         sclk_oe_n,
  input  wire        sclk_in,
  output reg         cs_out_n,
  input  wire        cs_in_n,
  output reg         mosi_out,
  input  wire        miso_in,
  input  wire        mosi_in,
  output reg         miso_out,
  // Interrupt request
  output wire        irq
);
  reg  [7:0]  cfg1_q, cfg2_q, tx_base_q, rx_base_q, cnt_lo_q, cnt_hi_q;
  reg  [7:0]  tx_buf_q, rx_buf_q, shift_q;
  reg         tx_full_q, rxf_q, ovr_q, busy_q, phase_q, sclk_in_q;
  reg  [3:0]  bit_q;
  reg  [11:0] done_q, tx_ptr_q, rx_ptr_q;
  reg         fetch_q;
  wire        master  = cfg1_q[`BIT_MSTR];
  wire        enabled = cfg1_q[`BIT_EN];
  wire        fast    = cfg2_q[`BIT_HS_START];
  wire        lsb     = cfg1_q[`BIT_LSB];
  wire        cpha    = cfg1_q[`BIT_CPHA];
  wire        cpol    = cfg1_q[`BIT_CPOL];
  wire        half_tick;
  wire [11:0] fast_count = {cnt_hi_q[3:0], cnt_lo_q};
  wire        wr_sfr = reg_wr & sfr_sel;
  wire        wr_sec = reg_wr & ~sfr_sel;
  wire        data_wr = wr_sfr & (reg_addr == `SFR_DATA_PORT);
  wire        slave_sel = ~master & ~cs_in_n & enabled;
  wire        s_edge = sclk_in ^ sclk_in_q;
  wire        tick = master ? half_tick : (slave_sel & s_edge);
  wire        out_bit = lsb ? shift_q[0] : shift_q[7];
  wire        in_bit = master ? miso_in : mosi_in;
  // Sample on the first edge when phase is 0, second edge otherwise.
  wire        sample = tick & busy_q & (phase_q == cpha);
  wire        byte_end = sample & (bit_q == `BYTE_BITS - 4'h1);
  wire [7:0]  rx_byte = lsb ? {in_bit, shift_q[7:1]} : {shift_q[6:0], in_bit};
  function [7:0] bit_reverse_if;
    input       rev;
    input [7:0] v;
    integer     i;
    begin
      for (i = 0; i < 8; i = i + 1)
        bit_reverse_if[i] = rev ? v[7 - i] : v[i];
    end
  endfunction
  spi_clock_divider u_div (
    .clk               (clk),
    .nrst              (nrst),
    .ce                (ce),
    .run               (busy_q & master & enabled),
    .clock_divider_sel (cfg2_q[2:0]),
    .half_tick         (half_tick)
  );
  assign irq = (rxf_q & cfg1_q[`BIT_RX_FULL_IRQ_ENABLE]) |
               (~tx_full_q & cfg1_q[`BIT_TX_EMPTY_IRQ_ENABLE] & enabled);
  always @* begin
    reg_rdata = 8'h00;
    if (sfr_sel) begin
      case (reg_addr)
        `SFR_CFG1:      reg_rdata = cfg1_q;
        `SFR_CFG2:      reg_rdata = {1'b0, cfg2_q[6:0]};
        `SFR_STATE:     reg_rdata = {5'h00, rxf_q, ovr_q, ~tx_full_q};
        `SFR_DATA_PORT: reg_rdata = rx_buf_q;
        default:        reg_rdata = 8'h00;
      endcase
    end else begin
      case (reg_addr)
        `SEC_TX_BASE:    reg_rdata = tx_base_q;
        `SEC_RX_BASE:    reg_rdata = rx_base_q;
        `SEC_COUNT_LOW:  reg_rdata = cnt_lo_q;
        `SEC_COUNT_HIGH: reg_rdata = {4'h0, cnt_hi_q[3:0]};
        default:         reg_rdata = 8'h00;
      endcase
    end
  end
  always @(posedge clk) begin
    if (!nrst) begin
      cfg1_q <= `CFG1_RESET;  cfg2_q <= `CFG2_RESET;
      tx_base_q <= 8'h00;     rx_base_q <= 8'h00;
      cnt_lo_q <= 8'h00;      cnt_hi_q <= 8'h00;
      tx_buf_q <= 8'h00;      rx_buf_q <= 8'h00;
      shift_q <= 8'h00;       tx_full_q <= 1'b0;
      rxf_q <= 1'b0;          ovr_q <= 1'b0;
      busy_q <= 1'b0;         phase_q <= 1'b0;
      bit_q <= 4'h0;          done_q <= 12'h000;
      tx_ptr_q <= 12'h000;    rx_ptr_q <= 12'h000;
      fetch_q <= 1'b0;        sclk_in_q <= 1'b0;
      sram_addr <= 12'h000;   sram_rd <= 1'b0;
      sram_wr <= 1'b0;        sram_wdata <= 8'h00;
      sclk_out <= 1'b0;       sclk_oe_n <= 1'b1;
      cs_out_n <= 1'b1;       mosi_out <= 1'b0;
      miso_out <= 1'b0;
    end else if (ce) begin
      sclk_in_q <= sclk_in;
      sram_rd   <= 1'b0;
      sram_wr   <= 1'b0;
      if (wr_sfr && reg_addr == `SFR_CFG1) cfg1_q <= reg_wdata;
      if (wr_sfr && reg_addr == `SFR_CFG2) begin
        cfg2_q <= {1'b0, reg_wdata[6:0]};
        if (reg_wdata[`BIT_HS_START] && !fast) begin
          tx_ptr_q <= {tx_base_q, 4'h0};
          rx_ptr_q <= {rx_base_q, 4'h0};
          done_q   <= 12'h000;
          fetch_q  <= 1'b1;
        end
      end
      if (wr_sec && reg_addr == `SEC_TX_BASE)    tx_base_q <= reg_wdata;
      if (wr_sec && reg_addr == `SEC_RX_BASE)    rx_base_q <= reg_wdata;
      if (wr_sec && reg_addr == `SEC_COUNT_LOW)  cnt_lo_q  <= reg_wdata;
      if (wr_sec && reg_addr == `SEC_COUNT_HIGH) cnt_hi_q  <= reg_wdata;
      // software clears by writing zero; hardware set still wins.
      if (wr_sfr && reg_addr == `SFR_STATE) begin
        if (!reg_wdata[`BIT_RXF]) rxf_q <= 1'b0;
        if (!reg_wdata[`BIT_OVR]) ovr_q <= 1'b0;
      end
      // fetch next transmit byte from SRAM
      if (fetch_q && fast && !busy_q) begin
        sram_addr <= tx_ptr_q;
        sram_rd   <= 1'b1;
        fetch_q   <= 1'b0;
      end
      if (sram_rd) begin
        shift_q  <= sram_rdata;
        busy_q   <= 1'b1;
        bit_q    <= 4'h0;
        phase_q  <= 1'b0;
        tx_ptr_q <= tx_ptr_q + 12'h001;
      end
      // idle write goes straight to shifter
      if (data_wr && !fast) begin
        if (!busy_q && !tx_full_q) begin
          shift_q <= reg_wdata;
          busy_q  <= 1'b1;
          bit_q   <= 4'h0;
          phase_q <= 1'b0;
        end else begin
          tx_buf_q  <= reg_wdata;
          tx_full_q <= 1'b1;
        end
      end
      // master keeps select low while data queued
      cs_out_n  <= ~(master & enabled & (busy_q | tx_full_q | fast));
      sclk_oe_n <= ~(master & enabled);
      // Polarity is only folded in while idle to avoid runt edges.
      if (!busy_q) sclk_out <= cpol;
      else if (master && half_tick) sclk_out <= ~sclk_out;
      // The sample itself shifts, so the line follows the shifter.
      if (busy_q) begin
        mosi_out <= out_bit;
        miso_out <= out_bit;
      end
      if (tick && busy_q) phase_q <= ~phase_q;
      if (sample) begin
        bit_q   <= bit_q + 4'h1;
        shift_q <= rx_byte;
      end
      if (byte_end) begin
        busy_q <= 1'b0;
        if (fast) begin
          sram_addr  <= rx_ptr_q;
          sram_wdata <= cfg2_q[`BIT_FEEDBACK] ? rx_byte :
                        bit_reverse_if(1'b0, rx_byte);
          sram_wr    <= 1'b1;
          rx_ptr_q   <= rx_ptr_q + 12'h001;
          done_q     <= done_q + 12'h001;
          if (done_q + 12'h001 == fast_count) begin
            cfg2_q[`BIT_HS_START] <= 1'b0;
            rxf_q <= 1'b1;
          end else begin
            fetch_q <= 1'b1;
          end
        end else begin
          if (rxf_q) begin
            ovr_q <= 1'b1;
          end else begin
            rx_buf_q <= rx_byte;
            rxf_q    <= 1'b1;
          end
          if (tx_full_q) begin
            shift_q   <= cfg2_q[`BIT_FEEDBACK] ? rx_byte : tx_buf_q;
            tx_full_q <= 1'b0;
            busy_q    <= 1'b1;
            bit_q     <= 4'h0;
            phase_q   <= 1'b0;
          end
        end
      end
      // Deselect in slave mode abandons a partial byte.
      if (!master && cs_in_n && busy_q && !data_wr) bit_q <= 4'h0;
    end
  end
endmodule // spi_buffered_serial_port

// File: spi_port_sva.sv
// Assertion checker for the buffered serial port.
`timescale 1ns/1ps
`include "spi_port_defines.vh"
module spi_port_sva (
  // Clock, reset, register bus
  input        clk, nrst, ce, sfr_sel, reg_wr,
  input  [7:0] reg_addr, reg_wdata,
  // SRAM and pins
  input        sram_rd, sram_wr, sclk_out, sclk_oe_n, irq,
  input [11:0] sram_addr
);
  reg  [7:0]  txb, rxb, cl, ch, c1, c2;
  reg  [11:0] n, la;
  reg  [3:0]  hc;
  wire        w  = reg_wr && ce;
  wire        go = w && sfr_sel && reg_addr == `SFR_CFG2 && reg_wdata[5];
  // Shadows let the checker predict addresses without seeing the body.
  always @(posedge clk) begin
    if (!nrst) begin
      txb <= 8'h00; rxb <= 8'h00; cl <= 8'h00; ch <= 8'h00;
      c1 <= `CFG1_RESET; c2 <= `CFG2_RESET; n <= 12'h000; hc <= 4'h0;
    end else begin
      if (w && !sfr_sel && reg_addr == `SEC_TX_BASE) txb <= reg_wdata;
      if (w && !sfr_sel && reg_addr == `SEC_RX_BASE) rxb <= reg_wdata;
      if (w && !sfr_sel && reg_addr == `SEC_COUNT_LOW) cl <= reg_wdata;
      if (w && !sfr_sel && reg_addr == `SEC_COUNT_HIGH) ch <= reg_wdata;
      if (w && sfr_sel && reg_addr == `SFR_CFG1) c1 <= reg_wdata;
      if (w && sfr_sel && reg_addr == `SFR_CFG2) c2 <= reg_wdata;
      if (go) n <= 12'h000; else if (sram_wr) n <= n + 12'h001;
      if ($changed(sclk_out)) hc <= 4'h0;
      else if (hc != 4'hF) hc <= hc + 4'h1;
    end
    if (sram_wr) la <= sram_addr;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_go; go; endsequence
  sequence s_fetch; sram_rd && sram_addr == {txb, 4'h0}; endsequence
  property p_tx_base; s_go |-> ##2 s_fetch; endproperty
  a_tx_base: assert property (p_tx_base)
    else $error("first fetch address wrong");
  property p_rx_base; sram_wr && n == 0 |-> sram_addr == {rxb, 4'h0};
  endproperty
  a_rx_base: assert property (p_rx_base)
    else $error("first store address wrong");
  property p_step; sram_wr && n != 0 |-> sram_addr == la + 12'h001;
  endproperty
  a_step: assert property (p_step)
    else $error("store pointer did not step by one");
  property p_count; sram_wr |-> n < {ch[3:0], cl}; endproperty
  a_count: assert property (p_count)
    else $error("store beyond programmed count");
  property p_wr_pulse; sram_wr |=> !sram_wr; endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("store strobe longer than one cycle");
  property p_rd_pulse; sram_rd |=> !sram_rd; endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("fetch strobe longer than one cycle");
  property p_irq_mask; !c1[7] && !c1[5] |-> !irq; endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("request raised with both enables off");
  property p_rate; $changed(sclk_out) && !sclk_oe_n |-> hc >= c2[2:0];
  endproperty
  a_rate: assert property (p_rate)
    else $error("serial clock faster than divider allows");
endmodule // spi_port_sva
bind spi_buffered_serial_port spi_port_sva i_spi_port_sva (
  .clk(clk), .nrst(nrst), .ce(ce), .sfr_sel(sfr_sel), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .sram_rd(sram_rd),
  .sram_wr(sram_wr), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
  .irq(irq), .sram_addr(sram_addr));

// File: spi_peer_model.sv
// Serial slave peer that echoes the master's bits, optionally inverted.
`timescale 1ns/1ps
module spi_peer_model (
  // Master-side pins
  input  wire clk, cs_n, mosi, inv,
  // Slave-side pins of the block
  output wire miso, sclk_s, cs_s_n, mosi_s
);
  reg tg = 1'b0;
  always @(posedge clk) tg <= ~tg;
  // never selects the block, so its clock stays idle.
  assign sclk_s = 1'b0;
  assign cs_s_n = 1'b1;
  assign mosi_s = tg;
  // A deselected slave floats; a moving pattern avoids false matches.
  assign miso = cs_n ? tg : mosi ^ inv;
endmodule // spi_peer_model

// File: spi_buffered_serial_port_tb.sv
// Self-checking bench for the buffered serial port.
`timescale 1ns/1ps
`include "spi_port_defines.vh"
module spi_buffered_serial_port_tb;
  reg         clk = 1'b0, nrst = 1'b0, sfr_sel = 1'b0, reg_wr = 1'b0;
  reg         reg_rd = 1'b0, inv = 1'b1, lsc = 1'b0;
  reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, v, mem [0:4095];
  wire [7:0]  reg_rdata, sram_wdata;
  wire [11:0] sram_addr;
  wire        sram_rd, sram_wr, sclk_out, sclk_oe_n, cs_out_n, mosi_out;
  wire        miso, sclk_s, cs_s_n, mosi_s, irq;
  integer     fail_count = 0, n_checks = 0, i, k, hp = 0, cyc = 0, csr = 0;
  spi_buffered_serial_port i_spi_buffered_serial_port (
    .clk(clk), .nrst(nrst), .ce(1'b1), .reg_addr(reg_addr),
    .sfr_sel(sfr_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sram_addr(sram_addr),
    .sram_rd(sram_rd), .sram_wr(sram_wr), .sram_wdata(sram_wdata),
    .sram_rdata(mem[sram_addr]), .sclk_out(sclk_out),
    .sclk_oe_n(sclk_oe_n), .sclk_in(sclk_s), .cs_out_n(cs_out_n),
    .cs_in_n(cs_s_n), .mosi_out(mosi_out), .miso_in(miso),
    .mosi_in(mosi_s), .miso_out(), .irq(irq));
  spi_peer_model i_spi_peer_model (.clk(clk), .cs_n(cs_out_n),
    .mosi(mosi_out), .inv(inv), .miso(miso), .sclk_s(sclk_s),
    .cs_s_n(cs_s_n), .mosi_s(mosi_s));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    if (sram_wr) mem[sram_addr] <= sram_wdata;
    if (sclk_out !== lsc) begin hp <= cyc; cyc <= 1; end
    else cyc <= cyc + 1;
    lsc <= sclk_out;
  end
  always @(posedge cs_out_n) csr = csr + 1;
  task chk(input [7:0] g, e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task wr(input sf, input [7:0] a, d);
    begin
      @(posedge clk);
      sfr_sel <= sf; reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input sf, input [7:0] a);
    begin
      @(posedge clk);
      sfr_sel <= sf; reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk);
      v = reg_rdata;
      reg_rd <= 1'b0;
    end
  endtask
  // Polls a status bit; running out of polls ends the run.
  task wait_bit(input [7:0] a, input integer b, input x);
    begin
      k = 0;
      rd(1, a);
      while (v[b] !== x && k < 6000) begin rd(1, a); k = k + 1; end
      if (k == 6000) begin fail_count = fail_count + 1; stop_test; end
    end
  endtask
  initial begin
    for (i = 0; i < 4096; i = i + 1) mem[i] = i[7:0] ^ 8'h5A;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(1, `SFR_CFG1); chk(v, `CFG1_RESET);
    rd(1, `SFR_CFG2); chk(v, `CFG2_RESET);
    rd(1, `SFR_STATE); chk(v, 8'h01);
    rd(1, `SFR_DATA_PORT); chk(v, 8'h00);
    rd(1, 8'hB7); chk(v, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      rd(0, 8'h3E + i[7:0]); chk(v, 8'h00);
      wr(0, 8'h3E + i[7:0], 8'h01 + 2 * i[7:0]);
      rd(0, 8'h3E + i[7:0]); chk(v, 8'h01 + 2 * i[7:0]);
    end
    $display("register test done");
    // each divider code 0 to 7 gives a half period of code plus one cycles.
    wr(1, `SFR_CFG1, 8'h54);
    for (i = 0; i < 8; i = i + 1) begin
      wr(1, `SFR_CFG2, 8'h18 | i[7:0]);
      wr(1, `SFR_DATA_PORT, 8'hA0 | i[7:0]);
      wait_bit(`SFR_STATE, 2, 1);
      chk(hp[7:0], i[7:0] + 8'h01);
      rd(1, `SFR_DATA_PORT); chk(v, ~(8'hA0 | i[7:0]));
      wr(1, `SFR_STATE, 8'hFB);
    end
    // First-edge sampling with the low bit first.
    wr(1, `SFR_CFG2, 8'h18);
    wr(1, `SFR_CFG1, 8'h52);
    wr(1, `SFR_DATA_PORT, 8'h2D);
    wait_bit(`SFR_STATE, 2, 1);
    rd(1, `SFR_DATA_PORT); chk(v, 8'hD2);
    wr(1, `SFR_STATE, 8'hFB);
    wr(1, `SFR_CFG2, 8'h1F);
    $display("divider test done");
    wr(1, `SFR_CFG1, 8'hD4);
    csr = 0;
    wr(1, `SFR_DATA_PORT, 8'h3C); rd(1, `SFR_STATE); chk(v, 8'h01);
    wr(1, `SFR_DATA_PORT, 8'h96); rd(1, `SFR_STATE); chk(v, 8'h00);
    wait_bit(`SFR_STATE, 2, 1); chk({7'h0, irq}, 8'h01);
    rd(1, `SFR_DATA_PORT); chk(v, 8'hC3);
    wr(1, `SFR_STATE, 8'hFB);
    @(negedge clk); chk({7'h0, irq}, 8'h00);
    chk(csr[7:0], 8'h00);
    wait_bit(`SFR_STATE, 2, 1);
    // written while the receive side still reads full.
    wr(1, `SFR_DATA_PORT, 8'h11);
    wait_bit(`SFR_STATE, 1, 1);
    rd(1, `SFR_DATA_PORT); chk(v, 8'h69);
    wr(1, `SFR_STATE, 8'hF9);
    wr(1, `SFR_CFG1, 8'h74);
    @(negedge clk); chk({7'h0, irq}, 8'h01);
    wr(1, `SFR_CFG1, 8'h54);
    $display("buffer test done");
    wr(0, `SEC_TX_BASE, 8'h02); wr(0, `SEC_RX_BASE, 8'h50);
    wr(0, `SEC_COUNT_LOW, 8'h03); wr(0, `SEC_COUNT_HIGH, 8'h01);
    wr(1, `SFR_CFG2, 8'h38);
    wait_bit(`SFR_CFG2, 5, 0); chk(v & 8'h20, 8'h00);
    rd(1, `SFR_STATE); chk(v & 8'h04, 8'h04);
    for (i = 0; i < 259; i = i + 1)
      chk(mem[1280 + i], ~((i[7:0] + 8'h20) ^ 8'h5A));
    chk(mem[1539], 8'h59);
    $display("fast test done");
    stop_test;
  end
endmodule // spi_buffered_serial_port_tb
